//--- verilog/sbpt_pkg.sv
// Constants shared by the sixteen-bit period timer and its input synchroniser.
// Assumes one system clock; the prescale counts below are in source ticks: clock cycles, gated cycles or pin edges.
package sbpt_pkg;
  localparam int          SBPT_WIDTH        = 16;
  localparam int          SBPT_PRE_WIDTH    = 8;
  localparam int          SBPT_SYNC_STAGES  = 2;
  // Prescale select encodings and their divide ratios.
  localparam logic [1:0]  SBPT_PS_DIV1      = 2'h0;
  localparam logic [1:0]  SBPT_PS_DIV8      = 2'h1;
  localparam logic [1:0]  SBPT_PS_DIV64     = 2'h2;
  localparam logic [1:0]  SBPT_PS_DIV256    = 2'h3;
  // Terminal value of the prescale counter for each ratio.
  localparam logic [7:0]  SBPT_PRE_LAST1    = 8'h00;
  localparam logic [7:0]  SBPT_PRE_LAST8    = 8'h07;
  localparam logic [7:0]  SBPT_PRE_LAST64   = 8'h3F;
  localparam logic [7:0]  SBPT_PRE_LAST256  = 8'hFF;
  // Values after reset.
  localparam logic [15:0] SBPT_COUNT_RESET  = 16'h0000;
  localparam logic [7:0]  SBPT_PRE_RESET    = 8'h00;
  // Control bit positions of the timer control word, kept for software images.
  localparam int          SBPT_BIT_TIMER_ON = 15;
  localparam int          SBPT_BIT_IDLE_STOP = 13;
  localparam int          SBPT_BIT_GATE_EN  = 6;
  localparam int          SBPT_BIT_PS_LO    = 4;
  localparam int          SBPT_BIT_SYNC_SEL = 2;
  localparam int          SBPT_BIT_CLK_SEL  = 1;
endpackage : sbpt_pkg

//--- verilog/sbpt_sync.sv
// Two-flop level synchroniser for a pin that arrives from outside the clock domain.
// Assumes the pin is a plain level; only the last stage may be read by other logic.
`timescale 1ns/1ps
module sbpt_sync
  import sbpt_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] sync_q;
  logic [W-1:0] sync_d;

  // The first stage feeds only the second stage.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Both stages clear on reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign sync_out = sync_q;
endmodule : sbpt_sync

//--- verilog/sbpt_timer.sv
// Sixteen-bit period timer: interval timer, synchronous or asynchronous counter.
// Assumes control bits are driven by same-clock logic; the pin and nothing else is synchronised.
// Functional notes
// - The block is a 16-bit up-counter usable as a real-time clock base or interval timer.
// - In timer mode it advances once per prescaled cycle to the period value, then wraps to zero.
// - In timer mode during idle it freezes when idle stop is set and resumes after idle.
// - In synchronous counter mode it advances on synchronised rising pin edges and wraps at the period.
// - In synchronous counter mode during idle it stops when idle stop is set and resumes after.
// - In asynchronous counter mode it advances on synchronised rising pin edges and wraps at the period.
// - In asynchronous counter mode entering idle stops it when idle stop is set.
// - A request is raised on a period match and on a falling edge of the gate pin.
// - With gating on, timer on and internal clock, it counts only while the gate pin is high.
// - A 1, 8, 64 or 256 prescaler clears on a count or control write while the timer is on, and on reset.
// - During sleep it runs only when on, on the external clock, and asynchronous.
// - A sticky match flag is set by hardware, cleared by software, and requests only when enabled.
`timescale 1ns/1ps
module sbpt_timer
  import sbpt_pkg::*;
#(
  parameter int WIDTH = SBPT_WIDTH
) (
  input  wire logic             CLOCK,
  input  wire logic             SYS_RST,
  input  wire logic             TIMER_ON,
  input  wire logic             IDLE_STOP,
  input  wire logic             GATE_ACCUMULATE_ENABLE,
  input  wire logic [1:0]       PRESCALE_SELECT,
  input  wire logic             EXTERNAL_SYNC_SELECT,
  input  wire logic             CLOCK_SOURCE_SELECT,
  input  wire logic             CONTROL_WRITE,
  input  wire logic             COUNT_WRITE,
  input  wire logic [WIDTH-1:0] COUNT_WDATA,
  input  wire logic [WIDTH-1:0] PERIOD_VALUE,
  input  wire logic             CPU_IDLE,
  input  wire logic             CPU_SLEEP,
  input  wire logic             EXTERNAL_CLOCK_GATE_PIN,
  input  wire logic             PERIOD_MATCH_IRQ_ENABLE,
  input  wire logic             FLAG_CLEAR,
  output logic      [WIDTH-1:0] COUNT_VALUE,
  output logic                  PERIOD_MATCH_FLAG,
  output logic                  MATCH_PULSE,
  output logic                  GATE_FALL_PULSE,
  output logic                  TIMER_IRQ
);
  logic             pin_sync;
  logic             pin_prev_q;
  logic             pin_prev_d;
  logic             pin_rise;
  logic             pin_fall;
  logic             gate_mode;
  logic             run;
  logic             raw_tick;
  logic             pre_tick;
  logic             pre_clear;
  logic             at_period;
  logic             match_ev;
  logic             gate_ev;
  logic [7:0]       pre_last;
  logic [7:0]       pre_q;
  logic [7:0]       pre_d;
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  logic             flag_q;
  logic             flag_d;
  logic             match_q;
  logic             match_d;
  logic             gfall_q;
  logic             gfall_d;
  logic             irq_q;
  logic             irq_d;

  // The pin is read only after two flops.
  sbpt_sync #(
    .W        (1)
  ) u_pin_sync (
    .clk      (CLOCK),
    .rst      (SYS_RST),
    .async_in (EXTERNAL_CLOCK_GATE_PIN),
    .sync_out (pin_sync)
  );

  // Edge detection and the run condition for idle and sleep.
  always_comb begin
    pin_prev_d = pin_sync;
    pin_rise   = pin_sync & ~pin_prev_q;
    pin_fall   = ~pin_sync & pin_prev_q;
    gate_mode  = TIMER_ON & GATE_ACCUMULATE_ENABLE & ~CLOCK_SOURCE_SELECT;
    run        = TIMER_ON
               & ~(CPU_IDLE & IDLE_STOP)
               & ~(CPU_SLEEP & ~(CLOCK_SOURCE_SELECT & ~EXTERNAL_SYNC_SELECT));
  end

  // Source tick: instruction cycles, gated cycles, or rising pin edges.
  always_comb begin
    if (CLOCK_SOURCE_SELECT) begin
      raw_tick = run & pin_rise;
    end else if (GATE_ACCUMULATE_ENABLE) begin
      raw_tick = run & pin_sync;
    end else begin
      raw_tick = run;
    end
  end

  // Prescaler divides the source tick and clears on writes while the timer is on.
  always_comb begin
    unique case (PRESCALE_SELECT)
      SBPT_PS_DIV1:   pre_last = SBPT_PRE_LAST1;
      SBPT_PS_DIV8:   pre_last = SBPT_PRE_LAST8;
      SBPT_PS_DIV64:  pre_last = SBPT_PRE_LAST64;
      SBPT_PS_DIV256: pre_last = SBPT_PRE_LAST256;
    endcase
    pre_clear = TIMER_ON & (COUNT_WRITE | CONTROL_WRITE);
    pre_tick  = raw_tick & (pre_q >= pre_last) & ~pre_clear;
    if (pre_clear) begin
      pre_d = SBPT_PRE_RESET;
    end else if (raw_tick) begin
      pre_d = (pre_q >= pre_last) ? SBPT_PRE_RESET : pre_q + 8'h01;
    end else begin
      pre_d = pre_q;
    end
  end

  // Counter counts up to the period value, then wraps to zero.
  always_comb begin
    at_period = (count_q == PERIOD_VALUE);
    match_ev  = pre_tick & at_period & ~COUNT_WRITE;
    if (COUNT_WRITE) begin
      count_d = COUNT_WDATA;
    end else if (pre_tick) begin
      count_d = at_period ? SBPT_COUNT_RESET : count_q + 16'h0001;
    end else begin
      count_d = count_q;
    end
  end

  // Sticky flag: a new event wins over a clear in the same cycle.
  always_comb begin
    gate_ev = gate_mode & pin_fall;
    match_d = match_ev;
    gfall_d = gate_ev;
    if (match_ev | gate_ev) begin
      flag_d = 1'b1;
    end else if (FLAG_CLEAR) begin
      flag_d = 1'b0;
    end else begin
      flag_d = flag_q;
    end
    irq_d = flag_d & PERIOD_MATCH_IRQ_ENABLE;
  end

  // All state registers.
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pin_prev_q <= 1'b0;
      pre_q      <= SBPT_PRE_RESET;
      count_q    <= SBPT_COUNT_RESET;
      flag_q     <= 1'b0;
      match_q    <= 1'b0;
      gfall_q    <= 1'b0;
      irq_q      <= 1'b0;
    end else begin
      pin_prev_q <= pin_prev_d;
      pre_q      <= pre_d;
      count_q    <= count_d;
      flag_q     <= flag_d;
      match_q    <= match_d;
      gfall_q    <= gfall_d;
      irq_q      <= irq_d;
    end
  end

  assign COUNT_VALUE       = count_q;
  assign PERIOD_MATCH_FLAG = flag_q;
  assign MATCH_PULSE       = match_q;
  assign GATE_FALL_PULSE   = gfall_q;
  assign TIMER_IRQ         = irq_q;

  // Checks on the counting, gating and flag behaviour.
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence s_hold_cond;
    !COUNT_WRITE && !CONTROL_WRITE;
  endsequence

  a_wrap_to_zero: assert property (pre_tick && at_period && !COUNT_WRITE |=> count_q == 16'h0000)
    else $error("counter did not wrap to zero at the period");
  a_count_step: assert property (pre_tick && !at_period && !COUNT_WRITE |=> count_q == $past(count_q) + 16'h0001)
    else $error("counter did not advance by one");
  a_idle_freeze: assert property (((CPU_IDLE && IDLE_STOP) and s_hold_cond) |=> $stable(count_q))
    else $error("counter moved during idle with idle stop set");
  a_gate_low_hold: assert property (GATE_ACCUMULATE_ENABLE && !CLOCK_SOURCE_SELECT && !pin_sync
                                    && !COUNT_WRITE |=> $stable(count_q))
    else $error("gated counter moved with gate low");
  a_sleep_stop: assert property (CPU_SLEEP && !(CLOCK_SOURCE_SELECT && !EXTERNAL_SYNC_SELECT)
                                 && !COUNT_WRITE |=> $stable(count_q))
    else $error("counter moved during sleep without async external clock");
  a_pre_clear: assert property (TIMER_ON && (COUNT_WRITE || CONTROL_WRITE) |=> pre_q == 8'h00)
    else $error("prescaler not cleared by a write");
  a_flag_set_wins: assert property ((match_ev || gate_ev) && FLAG_CLEAR
                                    |=> flag_q ##1 (flag_q || $past(FLAG_CLEAR)))
    else $error("event lost against a flag clear");
  a_match_pulse: assert property (match_q |-> flag_q && $past(pre_tick) && count_q == 16'h0000)
    else $error("match pulse without a wrap");
  a_gate_fall: assert property (gate_mode && pin_fall |=> GATE_FALL_PULSE && PERIOD_MATCH_FLAG)
    else $error("gate falling edge did not raise the flag");
  a_irq_follow: assert property (PERIOD_MATCH_IRQ_ENABLE && flag_d |=> TIMER_IRQ)
    else $error("enabled flag did not raise the request");
  a_ext_edge: assert property (((CLOCK_SOURCE_SELECT && !CPU_SLEEP && TIMER_ON && !CPU_IDLE && pin_rise
                                && PRESCALE_SELECT == SBPT_PS_DIV1) and s_hold_cond) |=> $changed(count_q)
                               || ($past(at_period) && count_q == 16'h0000))
    else $error("external edge did not advance the counter");

  // A clear with no event in the same cycle drops the flag and the request.
  a_flag_clear: assert property (FLAG_CLEAR && !match_ev && !gate_ev |=> !flag_q && !irq_q)
    else $error("flag clear did not drop the flag");
  // A disabled request stays low whatever the flag does.
  a_irq_masked: assert property (!PERIOD_MATCH_IRQ_ENABLE |=> !TIMER_IRQ)
    else $error("request raised while disabled");
  // A count write loads the written value on the next edge.
  a_count_load: assert property (COUNT_WRITE |=> COUNT_VALUE == $past(COUNT_WDATA))
    else $error("count write did not load the value");
endmodule : sbpt_timer

//--- dv/sbpt_pin_src.sv
// Pin source model: a clock or a gate level on the timer's pin.
// Assumes the bench clock; while run is low the pin holds level.
`timescale 1ns/1ps
module sbpt_pin_src (
  input  wire logic       clk,
  input  wire logic       run,
  input  wire logic       level,
  input  wire logic [3:0] half,
  output logic            pin
);
  logic [3:0] cnt_q;
  // Starts low so the pin is never unknown.
  initial begin
    cnt_q = 4'h0;
    pin = 1'h0;
  end
  // Toggles the pin every half cycles while running, else follows level.
  always @(posedge clk) begin
    cnt_q <= (!run || cnt_q == half - 4'h1) ? 4'h0 : cnt_q + 4'h1;
    pin <= !run ? level : ((cnt_q == half - 4'h1) ? !pin : pin);
  end
endmodule : sbpt_pin_src

//--- dv/testbench.sv
// Self-checking bench for the sixteen-bit period timer.
// Assumes the pin source model drives the clock or gate pin.
`timescale 1ns/1ps
module testbench;
  logic        clk = 1'h0;
  logic        rst, on, istop, gate, sync, src, cw, tw, idle, sleep, ien, fclr;
  logic        run, level, pin, flag, mp, gp, irq;
  logic [1:0]  ps;
  logic [15:0] wd, per, cnt;
  int          errors = 0;
  int          checks = 0;
  int          cyc = 0;
  int          dv[4] = '{1, 8, 64, 256};

  sbpt_timer sbpt_timer_i (.CLOCK(clk), .SYS_RST(rst), .TIMER_ON(on), .IDLE_STOP(istop),
    .GATE_ACCUMULATE_ENABLE(gate), .PRESCALE_SELECT(ps), .EXTERNAL_SYNC_SELECT(sync),
    .CLOCK_SOURCE_SELECT(src), .CONTROL_WRITE(cw), .COUNT_WRITE(tw), .COUNT_WDATA(wd),
    .PERIOD_VALUE(per), .CPU_IDLE(idle), .CPU_SLEEP(sleep), .EXTERNAL_CLOCK_GATE_PIN(pin),
    .PERIOD_MATCH_IRQ_ENABLE(ien), .FLAG_CLEAR(fclr), .COUNT_VALUE(cnt),
    .PERIOD_MATCH_FLAG(flag), .MATCH_PULSE(mp), .GATE_FALL_PULSE(gp), .TIMER_IRQ(irq));
  sbpt_pin_src sbpt_pin_src_i (.clk(clk), .run(run), .level(level), .half(4'h4), .pin(pin));

  // Free-running system clock of 40 ns.
  initial begin
    forever #20 clk = ~clk;
  end

  // Cuts a hung run short.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask : step

  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  // Counts the ticks seen over a window of n cycles.
  task automatic meas(input int n, input logic [15:0] d);
    logic [15:0] c0;
    c0 = cnt;
    step(n);
    chk(cnt - c0, d);
  endtask : meas

  // Writes the control bits and loads zero into the count.
  task automatic cfg(input logic [1:0] p, input logic s, y, g);
    {ps, src, sync, gate} = {p, s, y, g};
    {cw, tw, wd} = {2'h3, 16'h0000};
    step(1);
    {cw, tw} = 2'h0;
  endtask : cfg

  // Short period walk: wrap, match pulse, sticky flag, request and clear.
  task automatic t_walk(input logic e);
    per = 16'h0002;
    ien = e;
    cfg(2'h0, 1'h0, 1'h1, 1'h0);
    on = 1'h1;
    step(2);
    chk(cnt, 16'h0002);
    chk(16'(mp), 16'h0000);
    fclr = 1'h1;
    step(1);
    fclr = 1'h0;
    chk(cnt, 16'h0000);
    chk({13'h0, mp, flag, irq}, {13'h0, 2'h3, e});
    step(1);
    on = 1'h0;
    ien = 1'h1;
    chk({14'h0, mp, flag}, 16'h0001);
    step(2);
    chk(16'(irq), 16'h0001);
    fclr = 1'h1;
    step(1);
    fclr = 1'h0;
    step(1);
    chk({14'h0, flag, irq}, 16'h0000);
    $display("walk test done");
  endtask : t_walk

  // A count write mid-divide loads the count and restarts the prescaler.
  task automatic t_load;
    per = 16'hFFFF;
    on = 1'h1;
    cfg(2'h1, 1'h0, 1'h1, 1'h0);
    step(5);
    {tw, wd} = {1'h1, 16'h1234};
    step(1);
    tw = 1'h0;
    step(7);
    chk(cnt, 16'h1234);
    step(1);
    chk(cnt, 16'h1235);
    $display("load test done");
  endtask : t_load

  // Every prescale ratio gives four counts in four times its divisor.
  task automatic t_pre;
    per = 16'hFFFF;
    on = 1'h1;
    for (int i = 0; i < 4; i++) begin
      cfg(i[1:0], 1'h0, 1'h1, 1'h0);
      step(dv[i]);
      meas(dv[i] * 4, 16'h0004);
    end
    on = 1'h0;
    $display("prescale test done");
  endtask : t_pre

  // Gate level holds or releases counting; its fall raises the flag.
  task automatic t_gate;
    int k;
    cfg(2'h0, 1'h0, 1'h1, 1'h1);
    {run, level, on, fclr} = 4'h3;
    step(4);
    fclr = 1'h0;
    meas(8, 16'h0000);
    level = 1'h1;
    step(4);
    meas(8, 16'h0008);
    level = 1'h0;
    k = 0;
    while (gp !== 1'h1 && k < 8) begin
      step(1);
      k++;
    end
    chk({14'h0, gp, flag}, 16'h0003);
    {on, run} = 2'h1;
    $display("gate test done");
  endtask : t_gate

  // One clock source under idle stop, idle run, sleep and normal run.
  task automatic t_mode(input logic s, y, input logic [15:0] g);
    cfg(2'h0, s, y, 1'h0);
    {on, idle, istop} = 3'h7;
    step(4);
    meas(16, 16'h0000);
    istop = 1'h0;
    step(4);
    meas(16, g);
    {idle, istop, sleep} = 3'h3;
    step(4);
    meas(16, (s && !y) ? g : 16'h0000);
    sleep = 1'h0;
    step(4);
    meas(16, g);
    on = 1'h0;
    $display("mode test done");
  endtask : t_mode

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop

  // Resets the timer, then runs every test and reports.
  initial begin
    {rst, on, istop, gate, sync, src, cw, tw, idle, sleep, ien, fclr, run, level} = 14'h2000;
    {ps, wd, per} = {2'h0, 16'h0000, 16'hFFFF};
    repeat (10) @(negedge clk);
    rst = 1'h0;
    chk(cnt, 16'h0000);
    chk({12'h0, flag, mp, gp, irq}, 16'h0000);
    t_walk(1'h1);
    t_walk(1'h0);
    t_load();
    t_pre();
    t_gate();
    t_mode(1'h0, 1'h1, 16'h0010);
    t_mode(1'h1, 1'h1, 16'h0002);
    t_mode(1'h1, 1'h0, 16'h0002);
    report_and_stop();
  end
endmodule : testbench
